// ==== hw/valve_failsafe.sv ====
// Valve island output supervision: failsafe modes, aux supply check, keypad menu
`timescale 1ns/1ps
`default_nettype none
module valve_failsafe
    import valve_pkg::*;
#(
    parameter int TIMEOUT_CYC = LINK_TIMEOUT_CYC,
    parameter int BLINK_HALF = BLINK_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins from the field
    input wire logic aux_present_pin,
    input wire logic confirm_key_pin,
    input wire logic escape_key_pin,
    input wire logic up_key_pin,
    input wire logic down_key_pin,
    // Actuator side
    output logic [NUM_PILOTS-1:0] pilot_out,
    output logic [NUM_PILOTS-1:0] led_out,
    output logic [PWIDTH-1:0] setpt0_out,
    output logic [PWIDTH-1:0] setpt1_out,
    output logic valve_power_en,
    output logic link_active,
    output logic [7:0] status_byte,
    output logic irq
);
    // Synchronisers: three stages, change accepted when stages two and three agree
    logic [2:0] sync_aux, sync_ok, sync_esc, sync_up, sync_dn;
    logic aux_ok, key_ok, key_esc, key_up, key_dn;
    logic next_aux_ok, next_key_ok, next_key_esc, next_key_up, next_key_dn;
    logic key_ok_d, key_esc_d, key_up_d, key_dn_d;

    // Registers
    logic [31:0] ctrl, irq_stat, irq_mask, master_pilots, cycle_cnt;
    logic [PWIDTH-1:0] master_sp0, master_sp1, fault_p, held_sp0, held_sp1;
    logic [NUM_PILOTS-1:0] held_pilots;
    logic [31:0] next_ctrl, next_irq_stat, next_irq_mask, next_master_pilots, next_cycle_cnt;
    logic [PWIDTH-1:0] next_master_sp0, next_master_sp1, next_fault_p;
    logic [PWIDTH-1:0] next_held_sp0, next_held_sp1;
    logic [NUM_PILOTS-1:0] next_held_pilots;
    logic [31:0] next_prdata;
    logic next_pready;

    // Link watchdog and blink timer
    logic [$clog2(TIMEOUT_CYC+1)-1:0] wd_cnt, next_wd_cnt;
    logic [$clog2(BLINK_HALF+1)-1:0] blink_cnt, next_blink_cnt;
    logic blink, next_blink, link_ok, next_link_ok;

    // Keypad menu
    ui_state_t ui, next_ui;
    logic [$clog2(NUM_MENU)-1:0] sel, next_sel;
    logic mem_we;
    logic [PWIDTH-1:0] mem_wdata, mem_rdata;

    // Outputs
    logic [NUM_PILOTS-1:0] next_pilot_out, next_led_out;
    logic [PWIDTH-1:0] next_sp0, next_sp1;
    logic next_valve_power_en;
    logic [7:0] next_status_byte;
    logic next_irq;

    logic wr_acc, rd_setup, cycle_strobe;
    fs_mode_t mode;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign wr_acc = psel && penable && pwrite && pready;
    assign rd_setup = psel && !penable;
    // A write to the pilot register marks a valid process-data cycle
    assign cycle_strobe = wr_acc && hit(paddr, OFF_PILOTS);
    assign mode = fs_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);

    param_mem #(.DEPTH(NUM_MENU), .WIDTH(PWIDTH)) u_mem (
        .core_clk(core_clk),
        .rst(rst),
        .wr_en(mem_we),
        .wr_addr(sel),
        .wr_data(mem_wdata),
        .rd_addr(sel),
        .rd_data(mem_rdata)
    );

    // Debounced pin levels: the first stage feeds only the second
    always_comb begin
        next_aux_ok = (sync_aux[1] == sync_aux[2]) ? sync_aux[2] : aux_ok;
        next_key_ok = (sync_ok[1] == sync_ok[2]) ? sync_ok[2] : key_ok;
        next_key_esc = (sync_esc[1] == sync_esc[2]) ? sync_esc[2] : key_esc;
        next_key_up = (sync_up[1] == sync_up[2]) ? sync_up[2] : key_up;
        next_key_dn = (sync_dn[1] == sync_dn[2]) ? sync_dn[2] : key_dn;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            {sync_aux, sync_ok, sync_esc, sync_up, sync_dn} <= '0;
            {aux_ok, key_ok, key_esc, key_up, key_dn} <= '0;
            {key_ok_d, key_esc_d, key_up_d, key_dn_d} <= '0;
        end else begin
            sync_aux <= {sync_aux[1:0], aux_present_pin};
            sync_ok <= {sync_ok[1:0], confirm_key_pin};
            sync_esc <= {sync_esc[1:0], escape_key_pin};
            sync_up <= {sync_up[1:0], up_key_pin};
            sync_dn <= {sync_dn[1:0], down_key_pin};
            {aux_ok, key_ok, key_esc, key_up, key_dn} <=
                {next_aux_ok, next_key_ok, next_key_esc, next_key_up, next_key_dn};
            {key_ok_d, key_esc_d, key_up_d, key_dn_d} <= {key_ok, key_esc, key_up, key_dn};
        end
    end

    // Keypad: confirm alone views, both keys open the menu
    always_comb begin
        logic ok_rise, up_rise, dn_rise, esc_rise;
        ok_rise = key_ok && !key_ok_d;
        esc_rise = key_esc && !key_esc_d;
        up_rise = key_up && !key_up_d;
        dn_rise = key_dn && !key_dn_d;
        next_ui = ui;
        next_sel = sel;
        mem_we = 1'b0;
        mem_wdata = mem_rdata;
        unique case (ui)
            UI_IDLE: begin
                if (key_ok && key_esc && (ok_rise || esc_rise)) begin
                    next_ui = UI_MENU;
                end else if (ok_rise && !key_esc) begin
                    next_ui = UI_VIEW;
                end
            end
            UI_VIEW: begin
                if (key_ok && key_esc) begin
                    next_ui = UI_MENU;
                end else if (esc_rise || ok_rise) begin
                    next_ui = UI_IDLE;
                end
            end
            UI_MENU: begin
                // Confirm held selects value editing; otherwise arrows scroll
                if (esc_rise && !key_ok) begin
                    next_ui = UI_IDLE;
                end else if (key_ok && (up_rise || dn_rise)) begin
                    mem_we = 1'b1;
                    mem_wdata = up_rise ? mem_rdata + 1'b1 : mem_rdata - 1'b1;
                end else if (up_rise) begin
                    next_sel = sel + 1'b1;
                end else if (dn_rise) begin
                    next_sel = sel - 1'b1;
                end
            end
        endcase
    end

    // Menu state clears on restart, dropping keypad edits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ui <= UI_IDLE;
            sel <= '0;
        end else begin
            ui <= next_ui;
            sel <= next_sel;
        end
    end

    // Watchdog, blink and register next values
    always_comb begin
        next_wd_cnt = wd_cnt;
        next_link_ok = link_ok;
        if (cycle_strobe) begin
            next_wd_cnt = '0;
            next_link_ok = 1'b1;
        end else if (wd_cnt >= ($bits(wd_cnt))'(TIMEOUT_CYC - 1)) begin
            next_link_ok = 1'b0;
        end else begin
            next_wd_cnt = wd_cnt + 1'b1;
        end
        next_blink_cnt = blink_cnt + 1'b1;
        next_blink = blink;
        if (blink_cnt >= ($bits(blink_cnt))'(BLINK_HALF - 1)) begin
            next_blink_cnt = '0;
            next_blink = !blink;
        end

        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_master_pilots = master_pilots;
        next_master_sp0 = master_sp0;
        next_master_sp1 = master_sp1;
        next_fault_p = fault_p;
        next_cycle_cnt = cycle_cnt + (cycle_strobe ? 32'h0000_0001 : 32'h0000_0000);
        next_irq_stat = irq_stat;
        if (wr_acc) begin
            if (hit(paddr, OFF_CTRL)) next_ctrl = pwdata;
            if (hit(paddr, OFF_IRQ_MASK)) next_irq_mask = pwdata;
            if (hit(paddr, OFF_PILOTS)) next_master_pilots = pwdata;
            // Setpoints are raw millibar counts, independent of display unit
            if (hit(paddr, OFF_SETPT0)) next_master_sp0 = pwdata[PWIDTH-1:0];
            if (hit(paddr, OFF_SETPT1)) next_master_sp1 = pwdata[PWIDTH-1:0];
            if (hit(paddr, OFF_FAULT_P)) next_fault_p = pwdata[PWIDTH-1:0];
            if (hit(paddr, OFF_IRQ_STAT)) next_irq_stat = irq_stat & ~pwdata;
        end
        // Set wins over a clear in the same cycle
        if (link_ok && !next_link_ok) next_irq_stat[IRQ_LINK_LOST] = 1'b1;
        if (!link_ok && next_link_ok) next_irq_stat[IRQ_LINK_BACK] = 1'b1;
        if (aux_ok && !next_aux_ok) next_irq_stat[IRQ_AUX_LOST] = 1'b1;
        next_irq_stat[31:IRQ_BITS] = '0;

        // Snapshot taken every cycle the link is good, frozen once it drops
        next_held_pilots = link_ok ? master_pilots : held_pilots;
        next_held_sp0 = link_ok ? master_sp0 : held_sp0;
        next_held_sp1 = link_ok ? master_sp1 : held_sp1;

        next_pilot_out = master_pilots;
        next_sp0 = master_sp0;
        next_sp1 = master_sp1;
        if (!link_ok) begin
            unique case (mode)
                FS_RESET: next_pilot_out = '0;
                FS_HOLD: begin
                    next_pilot_out = held_pilots;
                    next_sp0 = held_sp0;
                    next_sp1 = held_sp1;
                end
                FS_SET: next_pilot_out = '1;
                FS_FAULT: begin
                    next_sp0 = fault_p;
                    next_sp1 = fault_p;
                end
            endcase
        end
        // Valve rail from aux only when enabled on a class B port
        next_valve_power_en = ctrl[CTRL_VALVE_ON] &&
            (!(ctrl[CTRL_AUX_EN] && ctrl[CTRL_CLASS_B]) || aux_ok);
        if (!next_valve_power_en) next_pilot_out = '0;
        next_led_out = next_pilot_out;
        if (ctrl[CTRL_AUX_EN] && ctrl[CTRL_CLASS_B] && !aux_ok) begin
            next_led_out = {NUM_PILOTS{blink}};
        end
        next_status_byte = (ctrl[CTRL_AUX_EN] && ctrl[CTRL_CLASS_B] && !aux_ok) ?
            AUX_ERR_CODE : STATUS_OK;
        next_irq = |(next_irq_stat & irq_mask);

        // APB: reads answer in the access cycle after setup
        next_pready = rd_setup;
        next_prdata = '0;
        if (rd_setup && !pwrite) begin
            unique case (paddr)
                OFF_CTRL: next_prdata = ctrl;
                OFF_STATUS: next_prdata = {22'h00_0000, ui == UI_MENU, ui == UI_VIEW,
                    status_byte};
                OFF_IRQ_STAT: next_prdata = irq_stat;
                OFF_IRQ_MASK: next_prdata = irq_mask;
                OFF_PILOTS: next_prdata = master_pilots;
                OFF_SETPT0: next_prdata = {16'h0000, master_sp0};
                OFF_SETPT1: next_prdata = {16'h0000, master_sp1};
                OFF_FAULT_P: next_prdata = {16'h0000, fault_p};
                OFF_PILOT_OUT: next_prdata = pilot_out;
                OFF_REG_OUT: next_prdata = {setpt1_out, setpt0_out};
                OFF_KEYPAD: next_prdata = {13'h0000, sel, mem_rdata};
                OFF_CYCLE: next_prdata = cycle_cnt;
                default: next_prdata = '0;
            endcase
        end
    end

    // Link keeps running regardless of valve rail state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wd_cnt <= '0;
            link_ok <= 1'b0;
            blink_cnt <= '0;
            blink <= 1'b0;
            ctrl <= CTRL_RESET;
            irq_stat <= '0;
            irq_mask <= '0;
            master_pilots <= '0;
            master_sp0 <= '0;
            master_sp1 <= '0;
            fault_p <= FAULT_P_RESET;
            cycle_cnt <= '0;
            held_pilots <= '0;
            held_sp0 <= '0;
            held_sp1 <= '0;
            pilot_out <= '0;
            led_out <= '0;
            setpt0_out <= '0;
            setpt1_out <= '0;
            valve_power_en <= 1'b0;
            link_active <= 1'b0;
            status_byte <= STATUS_OK;
            irq <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            wd_cnt <= next_wd_cnt;
            link_ok <= next_link_ok;
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            ctrl <= next_ctrl;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            master_pilots <= next_master_pilots;
            master_sp0 <= next_master_sp0;
            master_sp1 <= next_master_sp1;
            fault_p <= next_fault_p;
            cycle_cnt <= next_cycle_cnt;
            held_pilots <= next_held_pilots;
            held_sp0 <= next_held_sp0;
            held_sp1 <= next_held_sp1;
            pilot_out <= next_pilot_out;
            led_out <= next_led_out;
            setpt0_out <= next_sp0;
            setpt1_out <= next_sp1;
            valve_power_en <= next_valve_power_en;
            link_active <= next_link_ok;
            status_byte <= next_status_byte;
            irq <= next_irq;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= 1'b0;
        end
    end

    // Checks
    property p_reset_off;
        @(posedge core_clk) disable iff (rst)
        (!link_ok && mode == FS_RESET) |=> (pilot_out == '0);
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("pilots not off");
    property p_set_on;
        @(posedge core_clk) disable iff (rst)
        (!link_ok && mode == FS_SET && next_valve_power_en) |=> (pilot_out == '1);
    endproperty
    a_set_on: assert property (p_set_on) else $error("pilots not on");
    property p_hold;
        @(posedge core_clk) disable iff (rst)
        (link_ok && !next_link_ok) ##1 (mode == FS_HOLD && next_valve_power_en)[*2]
        |=> (pilot_out == $past(master_pilots, 3));
    endproperty
    a_hold: assert property (p_hold) else $error("hold value lost");
    property p_hold_sp;
        @(posedge core_clk) disable iff (rst)
        (!link_ok && mode == FS_HOLD) |=> (setpt0_out == $past(held_sp0));
    endproperty
    a_hold_sp: assert property (p_hold_sp) else $error("hold setpoint wrong");
    property p_fault;
        @(posedge core_clk) disable iff (rst)
        (!link_ok && mode == FS_FAULT) |=> (setpt1_out == $past(fault_p));
    endproperty
    a_fault: assert property (p_fault) else $error("fault pressure wrong");
    property p_resume;
        @(posedge core_clk) disable iff (rst)
        (link_ok && next_valve_power_en) |=> (pilot_out == $past(master_pilots));
    endproperty
    a_resume: assert property (p_resume) else $error("master data ignored");
    property p_status;
        @(posedge core_clk) disable iff (rst)
        (ctrl[CTRL_AUX_EN] && ctrl[CTRL_CLASS_B] && !aux_ok) |=> (status_byte == AUX_ERR_CODE);
    endproperty
    a_status: assert property (p_status) else $error("no aux error code");
    property p_leds;
        @(posedge core_clk) disable iff (rst)
        (ctrl[CTRL_AUX_EN] && ctrl[CTRL_CLASS_B] && !aux_ok) |=> (led_out == '0 || led_out == '1);
    endproperty
    a_leds: assert property (p_leds) else $error("leds not together");
    property p_strobe_link;
        @(posedge core_clk) disable iff (rst)
        cycle_strobe |=> link_active ##1 link_ok;
    endproperty
    a_strobe_link: assert property (p_strobe_link) else $error("link not restored");
    property p_menu;
        @(posedge core_clk) disable iff (rst)
        (ui == UI_IDLE && key_ok && key_esc && !key_ok_d && !key_esc_d) |=> (ui == UI_MENU);
    endproperty
    a_menu: assert property (p_menu) else $error("menu not opened");
    c_lost: cover property (@(posedge core_clk) disable iff (rst) link_ok ##1 !link_ok);
    c_menu: cover property (@(posedge core_clk) disable iff (rst) ui == UI_MENU);
    c_aux: cover property (@(posedge core_clk) disable iff (rst) status_byte == AUX_ERR_CODE);
endmodule
`default_nettype wire

// ==== hw/valve_pkg.sv ====
// Package: register map, field codes and timing for the valve failsafe block
package valve_pkg;
    localparam int NUM_PILOTS = 32;
    localparam int NUM_REGS = 2;
    localparam int PWIDTH = 16;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_PILOTS = 8'h10;
    localparam logic [7:0] OFF_SETPT0 = 8'h14;
    localparam logic [7:0] OFF_SETPT1 = 8'h18;
    localparam logic [7:0] OFF_FAULT_P = 8'h1C;
    localparam logic [7:0] OFF_PILOT_OUT = 8'h20;
    localparam logic [7:0] OFF_REG_OUT = 8'h24;
    localparam logic [7:0] OFF_KEYPAD = 8'h28;
    localparam logic [7:0] OFF_CYCLE = 8'h2C;
    // Control fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_AUX_EN = 2;
    localparam int CTRL_CLASS_B = 3;
    localparam int CTRL_VALVE_ON = 4;
    // Interrupt bits
    localparam int IRQ_LINK_LOST = 0;
    localparam int IRQ_LINK_BACK = 1;
    localparam int IRQ_AUX_LOST = 2;
    localparam int IRQ_BITS = 3;
    // Status byte error code for missing auxiliary supply
    localparam logic [7:0] AUX_ERR_CODE = 8'h21;
    localparam logic [7:0] STATUS_OK = 8'h00;
    // Reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] FAULT_P_RESET = 16'h0000;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int LINK_TIMEOUT_US = 100;
    localparam int LINK_TIMEOUT_CYC = LINK_TIMEOUT_US * CLK_MHZ;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
    localparam int NUM_MENU = 8;

    typedef enum logic [1:0] {
        FS_RESET,
        FS_HOLD,
        FS_SET,
        FS_FAULT
    } fs_mode_t;

    typedef enum {
        UI_IDLE,
        UI_VIEW,
        UI_MENU
    } ui_state_t;
endpackage

// ==== hw/param_mem.sv ====
// Small parameter store for keypad-edited menu values, registered read port
`timescale 1ns/1ps
`default_nettype none
module param_mem
    import valve_pkg::*;
#(
    parameter int DEPTH = NUM_MENU,
    parameter int WIDTH = PWIDTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Contents clear on restart so keypad edits never outlive a reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            rd_data <= '0;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ==== verification/apb_master_model.sv ====
// APB master standing in for the gateway that feeds the valve block
`timescale 1ns/1ps
`default_nettype none
module apb_master_model (
    // Clock
    input wire logic core_clk,
    // Bus
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    // One transfer; request held until pready is seen at an edge
    // Process data goes as whole 32-bit words, wide enough for the port setup
    // No cycle limit here: only the bench watchdog ends a stuck wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            do begin
                @(posedge core_clk);
            end while (pready !== 1'b1);
            r = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== verification/valve_island_failsafe_control_test.sv ====
// Self-checking bench for the valve failsafe block
`timescale 1ns/1ps
`default_nettype none
module valve_island_failsafe_control_test;
    import valve_pkg::*;
    localparam int TO = 50;
    typedef struct {logic [1:0] m; logic [31:0] p, pm; logic [15:0] s, sm;} row_t;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, status_byte;
    logic [31:0] pwdata, prdata, pilot_out, led_out, t;
    logic [15:0] sp0, sp1;
    logic aux, k_ok, k_esc, k_up, k_dn, vpow, link, on_seen;
    int n_fail = 0;
    int comparisons = 0;
    row_t rows[4];
    // Gateway stand-in drives the bus
    apb_master_model m (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
    valve_failsafe #(.TIMEOUT_CYC(TO), .BLINK_HALF(8)) DUT (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .aux_present_pin(aux),
        .confirm_key_pin(k_ok), .escape_key_pin(k_esc), .up_key_pin(k_up),
        .down_key_pin(k_dn), .pilot_out(pilot_out), .led_out(led_out),
        .setpt0_out(sp0), .setpt1_out(sp1), .valve_power_en(vpow),
        .link_active(link), .status_byte(status_byte), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        m.xfer(1'b1, a, d, t);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        m.xfer(1'b0, a, 32'h0000_0000, t);
        chk(t & k, e & k);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Key press held long enough for the pin synchronisers
    task automatic key(input logic ok, input logic escape_key, input logic up, input logic dn);
        k_ok <= ok;
        k_esc <= escape_key;
        k_up <= up;
        k_dn <= dn;
        cyc(8);
        k_ok <= 1'b0;
        k_esc <= 1'b0;
        k_up <= 1'b0;
        k_dn <= 1'b0;
        cyc(8);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        final_report();
    end
    initial begin
        rows[0] = '{FS_RESET, 32'h0000_0000, 32'hFFFF_FFFF, 16'h0000, 16'h0000};
        rows[1] = '{FS_HOLD, 32'hA5A5_0F0F, 32'hFFFF_FFFF, 16'h1234, 16'hFFFF};
        rows[2] = '{FS_SET, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0000, 16'h0000};
        rows[3] = '{FS_FAULT, 32'h0000_0000, 32'h0000_0000, 16'h0500, 16'hFFFF};
        rst = 1'b1;
        {aux, k_ok, k_esc, k_up, k_dn} = 5'b10000;
        cyc(4);
        rst <= 1'b0;
        chk({link, vpow, status_byte}, 32'h0000_0000);
        // Each failsafe mode: run the link, let it time out, restore it
        foreach (rows[i]) begin
            wr(OFF_CTRL, {27'h0, 1'b1, 2'b00, rows[i].m});
            wr(OFF_SETPT0, 32'h0000_1234);
            wr(OFF_FAULT_P, 32'h0000_0500);
            wr(OFF_PILOTS, 32'hA5A5_0F0F);
            cyc(3);
            chk({link, pilot_out[30:0]}, 32'hA5A5_0F0F);
            cyc(TO + 10);
            chk({31'h0, link}, 32'h0000_0000);
            chk(pilot_out & rows[i].pm, rows[i].p & rows[i].pm);
            chk({16'h0, sp0 & rows[i].sm}, {16'h0, rows[i].s & rows[i].sm});
            wr(OFF_PILOTS, 32'h0000_0000);
            cyc(3);
            chk({link, pilot_out[30:0]}, 32'h8000_0000);
        end
        // Missing aux supply on a two-supply port
        wr(OFF_CTRL, 32'h0000_001C);
        wr(OFF_IRQ_MASK, 32'h0000_0004);
        wr(OFF_IRQ_STAT, 32'h0000_0007);
        aux <= 1'b0;
        cyc(10);
        wr(OFF_PILOTS, 32'hFFFF_FFFF);
        cyc(3);
        chk({link, 15'h0, pilot_out[15:0]}, 32'h8000_0000);
        chk({24'h0, status_byte}, {24'h0, AUX_ERR_CODE});
        on_seen = 1'b0;
        for (int c = 0; c < 20; c++) begin
            cyc(1);
            if (led_out !== 32'h0000_0000) chk(led_out, 32'hFFFF_FFFF);
            if (led_out === 32'hFFFF_FFFF) on_seen = 1'b1;
        end
        chk({31'h0, on_seen}, 32'h0000_0001);
        rdchk(OFF_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        cyc(2);
        chk({31'h0, irq}, 32'h0000_0000);
        aux <= 1'b1;
        cyc(10);
        wr(OFF_IRQ_STAT, 32'h0000_0007);
        rdchk(OFF_IRQ_STAT, 32'h0000_0000, 32'h0000_0004);
        chk({24'h0, status_byte}, {24'h0, STATUS_OK});
        // Keypad: view, leave, menu, scroll
        key(1'b1, 1'b0, 1'b0, 1'b0);
        rdchk(OFF_STATUS, 32'h0000_0100, 32'h0000_0300);
        key(1'b0, 1'b1, 1'b0, 1'b0);
        key(1'b1, 1'b1, 1'b0, 1'b0);
        rdchk(OFF_STATUS, 32'h0000_0200, 32'h0000_0300);
        key(1'b0, 1'b0, 1'b1, 1'b0);
        rdchk(OFF_KEYPAD, 32'h0001_0000, 32'h0007_0000);
        // Confirm held with up edits the value, down scrolls back
        key(1'b1, 1'b0, 1'b1, 1'b0);
        rdchk(OFF_KEYPAD, 32'h0001_0001, 32'h0007_FFFF);
        key(1'b0, 1'b0, 1'b0, 1'b1);
        rdchk(OFF_KEYPAD, 32'h0000_0000, 32'h0007_FFFF);
        // Mid-run restart must drop the keypad edit
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
        chk({link, vpow, status_byte}, 32'h0000_0000);
        rdchk(OFF_STATUS, 32'h0000_0000, 32'h0000_0300);
        key(1'b1, 1'b1, 1'b0, 1'b0);
        key(1'b0, 1'b0, 1'b1, 1'b0);
        rdchk(OFF_KEYPAD, 32'h0001_0000, 32'h0007_FFFF);
        rdchk(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        final_report();
    end
endmodule
`default_nettype wire
